// file: hdl/smb_status_bank.sv
// live supervisory status registers behind the serial control port
`timescale 1ns/1ps
module smb_status_bank
  import smb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire smb_status_in_t status_i,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] conv_pair(
    input logic ov_lo, input logic uv_lo, input logic il_lo,
    input logic ov_hi, input logic uv_hi, input logic il_hi);
    logic [7:0] v;
    v = SMB_RESET_VAL;
    v[SMB_BIT_OV] = ov_lo;
    v[SMB_BIT_UV] = uv_lo;
    v[SMB_BIT_ILIM] = il_lo;
    v[SMB_HI_CONV + SMB_BIT_OV] = ov_hi;
    v[SMB_HI_CONV + SMB_BIT_UV] = uv_hi;
    v[SMB_HI_CONV + SMB_BIT_ILIM] = il_hi;
    return v & SMB_MASK_CONV;
  endfunction

  function automatic logic [7:0] read_reg(
    input logic [7:0] addr, input smb_regs_t r);
    logic [7:0] v;
    v = SMB_UNMAPPED_VAL;
    unique case (addr)
      SMB_OFS_CONV12: v = r.conv12;
      SMB_OFS_CONV34: v = r.conv34;
      SMB_OFS_VMON: v = r.vmon;
      SMB_OFS_STARTUP: v = r.startup;
      SMB_OFS_MISC: v = r.misc;
      SMB_OFS_MODERATE: v = r.moderate;
      default: v = SMB_UNMAPPED_VAL;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  smb_status_in_t st_s;
  // select kept inverted so the flop reset value means no frame
  logic frame_sel_s;
  logic sclk_s;
  logic mosi_s;

  smb_sync #(
    .W(SMB_STATUS_W + 3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({status_i, ~spi_cs_n, spi_sclk, spi_mosi}),
    .q({st_s, frame_sel_s, sclk_s, mosi_s})
  );

  // ---------------------------------------------------------------
  // status registers
  // ---------------------------------------------------------------
  smb_regs_t regs_r;
  smb_regs_t regs_nxt;

  always_comb begin
    regs_nxt = '0;
    regs_nxt.conv12 = conv_pair(
      st_s.conv_overvoltage[0], st_s.conv_undervoltage[0],
      st_s.conv_current_limit[0],
      st_s.conv_overvoltage[1], st_s.conv_undervoltage[1],
      st_s.conv_current_limit[1]);
    regs_nxt.conv34 = conv_pair(
      st_s.conv_overvoltage[2], st_s.conv_undervoltage[2],
      st_s.conv_current_limit[2],
      st_s.conv_overvoltage[3], st_s.conv_undervoltage[3],
      st_s.conv_current_limit[3]);
    regs_nxt.vmon[SMB_BIT_MON1_UV] = st_s.monitor1_undervoltage;
    regs_nxt.vmon[SMB_BIT_MON1_OV] = st_s.monitor1_overvoltage;
    regs_nxt.vmon[SMB_BIT_MON2_UV] = st_s.monitor2_undervoltage;
    regs_nxt.vmon[SMB_BIT_MON2_OV] = st_s.monitor2_overvoltage;
    regs_nxt.vmon[SMB_BIT_ANA_UV] =
      st_s.analog_supply_undervoltage;
    regs_nxt.vmon[SMB_BIT_ANA_OV] =
      st_s.analog_supply_overvoltage;
    regs_nxt.startup[SMB_BIT_ENABLE] = st_s.enable_pin;
    regs_nxt.misc[SMB_BIT_TWARN] = st_s.thermal_warning;
    regs_nxt.misc[SMB_BIT_EXT_CLK] =
      st_s.external_clock_invalid;
    regs_nxt.moderate[SMB_BIT_TSD_SEQ] =
      st_s.thermal_sequenced_shutdown;
  end

  // live copy every cycle, no latching
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r <= '0;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  smb_state_t state_r;
  smb_state_t state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic sclk_prev_r;
  logic sclk_prev_nxt;
  logic miso_nxt;
  logic miso_oe_nxt;
  logic rise;
  logic fall;

  always_comb begin
    rise = sclk_s & ~sclk_prev_r;
    fall = ~sclk_s & sclk_prev_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    shift_nxt = shift_r;
    sclk_prev_nxt = sclk_s;
    miso_nxt = spi_miso;
    miso_oe_nxt = spi_miso_oe;
    if (!frame_sel_s) begin
      state_nxt = SMB_IDLE;
      miso_oe_nxt = 1'b0;
      miso_nxt = 1'b0;
    end else begin
      unique case (state_r)
        SMB_IDLE: begin
          state_nxt = SMB_ADDR;
          cnt_nxt = SMB_CNT_ZERO;
          miso_oe_nxt = 1'b1;
          miso_nxt = 1'b0;
        end
        SMB_ADDR: begin
          if (rise) begin
            addr_nxt = {addr_r[6:0], mosi_s};
            cnt_nxt = cnt_r + SMB_CNT_ONE;
            if (cnt_r == SMB_LAST_BIT) begin
              state_nxt = SMB_DATA;
              cnt_nxt = SMB_CNT_ZERO;
              shift_nxt = read_reg({addr_r[6:0], mosi_s}, regs_r);
            end
          end
        end
        SMB_DATA: begin
          // data clocked in here is dropped: the bank is read-only
          if (fall) begin
            miso_nxt = shift_r[7];
            shift_nxt = {shift_r[6:0], 1'b0};
          end
          if (rise) begin
            cnt_nxt = cnt_r + SMB_CNT_ONE;
            if (cnt_r == SMB_LAST_BIT) begin
              state_nxt = SMB_DONE;
            end
          end
        end
        SMB_DONE: begin
          state_nxt = SMB_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SMB_IDLE;
      cnt_r <= SMB_CNT_ZERO;
      addr_r <= SMB_RESET_VAL;
      shift_r <= SMB_RESET_VAL;
      sclk_prev_r <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      shift_r <= shift_nxt;
      sclk_prev_r <= sclk_prev_nxt;
      spi_miso <= miso_nxt;
      spi_miso_oe <= miso_oe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // a raw level held three samples reaches its register bit next cycle
  sequence s_held_hi(logic raw);
    raw [*3];
  endsequence

  sequence s_held_lo(logic raw);
    !raw [*3];
  endsequence

  property p_track(logic raw, logic bitv);
    @(posedge clk) disable iff (!rst_n)
      (s_held_hi(raw) |=> bitv) and (s_held_lo(raw) |=> !bitv);
  endproperty

  conv1_overvoltage_a: assert property (p_track(
    status_i.conv_overvoltage[0], regs_r.conv12[SMB_BIT_OV]))
    else $error("converter 1 over-voltage bit wrong");
  conv2_current_limit_a: assert property (p_track(
    status_i.conv_current_limit[1],
    regs_r.conv12[SMB_HI_CONV + SMB_BIT_ILIM]))
    else $error("converter 2 current limit bit wrong");
  conv3_undervoltage_a: assert property (p_track(
    status_i.conv_undervoltage[2], regs_r.conv34[SMB_BIT_UV]))
    else $error("converter 3 under-voltage bit wrong");
  conv4_overvoltage_a: assert property (p_track(
    status_i.conv_overvoltage[3],
    regs_r.conv34[SMB_HI_CONV + SMB_BIT_OV]))
    else $error("converter 4 over-voltage bit wrong");
  monitor1_under_a: assert property (p_track(
    status_i.monitor1_undervoltage, regs_r.vmon[SMB_BIT_MON1_UV]))
    else $error("monitor 1 under-voltage bit wrong");
  monitor2_over_a: assert property (p_track(
    status_i.monitor2_overvoltage, regs_r.vmon[SMB_BIT_MON2_OV]))
    else $error("monitor 2 over-voltage bit wrong");
  analog_under_a: assert property (p_track(
    status_i.analog_supply_undervoltage, regs_r.vmon[SMB_BIT_ANA_UV]))
    else $error("analog supply under-voltage bit wrong");
  enable_level_a: assert property (p_track(
    status_i.enable_pin, regs_r.startup[SMB_BIT_ENABLE]))
    else $error("enable level bit wrong");
  thermal_warn_a: assert property (p_track(
    status_i.thermal_warning, regs_r.misc[SMB_BIT_TWARN]))
    else $error("thermal warning bit wrong");
  ext_clock_a: assert property (p_track(
    status_i.external_clock_invalid, regs_r.misc[SMB_BIT_EXT_CLK]))
    else $error("external clock bit wrong");
  seq_shutdown_a: assert property (p_track(
    status_i.thermal_sequenced_shutdown,
    regs_r.moderate[SMB_BIT_TSD_SEQ]))
    else $error("sequenced shutdown bit wrong");
  conv1_under_a: assert property (p_track(
    status_i.conv_undervoltage[0], regs_r.conv12[SMB_BIT_UV]))
    else $error("converter 1 under-voltage bit wrong");
  conv1_limit_a: assert property (p_track(
    status_i.conv_current_limit[0], regs_r.conv12[SMB_BIT_ILIM]))
    else $error("converter 1 current limit bit wrong");
  conv2_over_a: assert property (p_track(
    status_i.conv_overvoltage[1],
    regs_r.conv12[SMB_HI_CONV + SMB_BIT_OV]))
    else $error("converter 2 over-voltage bit wrong");
  conv2_under_a: assert property (p_track(
    status_i.conv_undervoltage[1],
    regs_r.conv12[SMB_HI_CONV + SMB_BIT_UV]))
    else $error("converter 2 under-voltage bit wrong");
  conv3_over_a: assert property (p_track(
    status_i.conv_overvoltage[2], regs_r.conv34[SMB_BIT_OV]))
    else $error("converter 3 over-voltage bit wrong");
  conv3_limit_a: assert property (p_track(
    status_i.conv_current_limit[2], regs_r.conv34[SMB_BIT_ILIM]))
    else $error("converter 3 current limit bit wrong");
  conv4_under_a: assert property (p_track(
    status_i.conv_undervoltage[3],
    regs_r.conv34[SMB_HI_CONV + SMB_BIT_UV]))
    else $error("converter 4 under-voltage bit wrong");
  conv4_limit_a: assert property (p_track(
    status_i.conv_current_limit[3],
    regs_r.conv34[SMB_HI_CONV + SMB_BIT_ILIM]))
    else $error("converter 4 current limit bit wrong");
  monitor1_over_a: assert property (p_track(
    status_i.monitor1_overvoltage, regs_r.vmon[SMB_BIT_MON1_OV]))
    else $error("monitor 1 over-voltage bit wrong");
  monitor2_under_a: assert property (p_track(
    status_i.monitor2_undervoltage, regs_r.vmon[SMB_BIT_MON2_UV]))
    else $error("monitor 2 under-voltage bit wrong");
  analog_over_a: assert property (p_track(
    status_i.analog_supply_overvoltage, regs_r.vmon[SMB_BIT_ANA_OV]))
    else $error("analog supply over-voltage bit wrong");
  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      ((regs_r.conv12 & ~SMB_MASK_CONV) == 8'h00) &&
      ((regs_r.conv34 & ~SMB_MASK_CONV) == 8'h00) &&
      ((regs_r.vmon & ~SMB_MASK_VMON) == 8'h00) &&
      ((regs_r.startup & ~SMB_MASK_STARTUP) == 8'h00) &&
      ((regs_r.misc & ~SMB_MASK_MISC) == 8'h00) &&
      ((regs_r.moderate & ~SMB_MASK_MODERATE) == 8'h00))
    else $error("reserved status bit reads nonzero");

  sequence s_addr_to_data;
    (state_r == SMB_ADDR) ##1 (state_r == SMB_DATA);
  endsequence

  read_load_a: assert property (
    @(posedge clk) disable iff (!rst_n)
      s_addr_to_data |-> shift_r == read_reg(addr_r, $past(regs_r)))
    else $error("read data not taken from addressed register");

endmodule // smb_status_bank

// file: hdl/smb_pkg.sv
// constants, types and layouts of the supply monitor status bank
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package smb_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SMB_OFS_CONV12 = 8'h6d;
  localparam logic [7:0] SMB_OFS_CONV34 = 8'h6e;
  localparam logic [7:0] SMB_OFS_VMON = 8'h72;
  localparam logic [7:0] SMB_OFS_STARTUP = 8'h73;
  localparam logic [7:0] SMB_OFS_MISC = 8'h74;
  localparam logic [7:0] SMB_OFS_MODERATE = 8'h75;

  localparam logic [7:0] SMB_RESET_VAL = 8'h00;
  localparam logic [7:0] SMB_UNMAPPED_VAL = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SMB_BIT_OV = 0;
  localparam int SMB_BIT_UV = 1;
  localparam int SMB_BIT_ILIM = 3;
  localparam int SMB_HI_CONV = 4;
  localparam int SMB_BIT_ANA_OV = 0;
  localparam int SMB_BIT_ANA_UV = 1;
  localparam int SMB_BIT_MON1_OV = 2;
  localparam int SMB_BIT_MON1_UV = 3;
  localparam int SMB_BIT_MON2_OV = 5;
  localparam int SMB_BIT_MON2_UV = 6;
  localparam int SMB_BIT_ENABLE = 1;
  localparam int SMB_BIT_EXT_CLK = 1;
  localparam int SMB_BIT_TWARN = 3;
  localparam int SMB_BIT_TSD_SEQ = 0;

  // implemented bits per register, the rest read zero
  localparam logic [7:0] SMB_MASK_CONV = 8'hbb;
  localparam logic [7:0] SMB_MASK_VMON = 8'h6f;
  localparam logic [7:0] SMB_MASK_STARTUP = 8'h02;
  localparam logic [7:0] SMB_MASK_MISC = 8'h0a;
  localparam logic [7:0] SMB_MASK_MODERATE = 8'h01;

  // ---------------------------------------------------------------
  // serial frame: 8 address bits then 8 data bits, msb first
  // ---------------------------------------------------------------
  localparam int SMB_BYTE_BITS = 8;
  localparam logic [2:0] SMB_LAST_BIT = 3'h7;
  localparam logic [2:0] SMB_CNT_ZERO = 3'h0;
  localparam logic [2:0] SMB_CNT_ONE = 3'h1;

  typedef enum logic [1:0] {
    SMB_IDLE = 2'h0,
    SMB_ADDR = 2'h1,
    SMB_DATA = 2'h3,
    SMB_DONE = 2'h2
  } smb_state_t;

  // index 0 is converter 1
  typedef struct packed {
    logic [3:0] conv_overvoltage;
    logic [3:0] conv_undervoltage;
    logic [3:0] conv_current_limit;
    logic monitor1_undervoltage;
    logic monitor1_overvoltage;
    logic monitor2_undervoltage;
    logic monitor2_overvoltage;
    logic analog_supply_undervoltage;
    logic analog_supply_overvoltage;
    logic enable_pin;
    logic thermal_warning;
    logic external_clock_invalid;
    logic thermal_sequenced_shutdown;
  } smb_status_in_t;

  typedef struct packed {
    logic [7:0] conv12;
    logic [7:0] conv34;
    logic [7:0] vmon;
    logic [7:0] startup;
    logic [7:0] misc;
    logic [7:0] moderate;
  } smb_regs_t;

  localparam int SMB_STATUS_W = $bits(smb_status_in_t);

endpackage

// file: hdl/smb_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module smb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end

endmodule // smb_sync

// file: testbench/smb_status_bank_test.sv
// self-checking bench for the supply monitor status bank
`timescale 1ns/1ps
module smb_status_bank_test
  import smb_pkg::*;
;

  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic clk;
  logic rst_n;
  logic spi_cs_n;
  logic spi_sclk;
  logic spi_mosi;
  logic spi_miso;
  logic spi_miso_oe;
  smb_status_in_t status_i;
  int errors;
  int samples_checked;

  smb_status_bank i_smb_status_bank (
    .clk(clk),
    .rst_n(rst_n),
    .status_i(status_i),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen,
               exp);
    end
  endtask

  task automatic summarize;
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // expected register images from the live levels
  function automatic smb_regs_t expect_regs(input smb_status_in_t s);
    smb_regs_t r;
    r.conv12 = {s.conv_current_limit[1], 1'b0, s.conv_undervoltage[1],
                s.conv_overvoltage[1], s.conv_current_limit[0], 1'b0,
                s.conv_undervoltage[0], s.conv_overvoltage[0]};
    r.conv34 = {s.conv_current_limit[3], 1'b0, s.conv_undervoltage[3],
                s.conv_overvoltage[3], s.conv_current_limit[2], 1'b0,
                s.conv_undervoltage[2], s.conv_overvoltage[2]};
    r.vmon = {1'b0, s.monitor2_undervoltage, s.monitor2_overvoltage, 1'b0,
              s.monitor1_undervoltage, s.monitor1_overvoltage,
              s.analog_supply_undervoltage, s.analog_supply_overvoltage};
    r.startup = {6'h00, s.enable_pin, 1'b0};
    r.misc = {4'h0, s.thermal_warning, 1'b0, s.external_clock_invalid,
              1'b0};
    r.moderate = {7'h00, s.thermal_sequenced_shutdown};
    return r;
  endfunction

  // one frame; the data byte sent is all ones and must be ignored
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] d);
    spi_cs_n <= 1'b0;
    tick(6);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= addr[i];
      tick(4);
      spi_sclk <= 1'b1;
      tick(4);
      spi_sclk <= 1'b0;
    end
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= 1'b1;
      tick(4);
      @(negedge clk);
      d[i] = spi_miso;
      if (i == 0) begin
        check({7'h00, spi_miso_oe}, 8'h01);
      end
      @(posedge clk);
      spi_sclk <= 1'b1;
      tick(4);
      spi_sclk <= 1'b0;
    end
    tick(4);
    spi_cs_n <= 1'b1;
    spi_mosi <= 1'b0;
    tick(6);
    @(negedge clk);
    check({6'h00, spi_miso_oe, spi_miso}, 8'h00);
    @(posedge clk);
  endtask

  task automatic check_all(input smb_status_in_t s);
    smb_regs_t e;
    logic [7:0] d;
    e = expect_regs(s);
    status_i <= s;
    tick(6);
    read_reg(SMB_OFS_CONV12, d);
    check(d, e.conv12);
    read_reg(SMB_OFS_CONV34, d);
    check(d, e.conv34);
    read_reg(SMB_OFS_VMON, d);
    check(d, e.vmon);
    read_reg(SMB_OFS_STARTUP, d);
    check(d, e.startup);
    read_reg(SMB_OFS_MISC, d);
    check(d, e.misc);
    read_reg(SMB_OFS_MODERATE, d);
    check(d, e.moderate);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset_values;
    logic [7:0] d;
    @(negedge clk);
    check({6'h00, spi_miso_oe, spi_miso}, 8'h00);
    @(posedge clk);
    check_all('0);
    read_reg(8'h70, d);
    check(d, 8'h00);
  endtask

  // each condition alone lands on its own bit and nowhere else
  task automatic test_walk_one;
    logic [SMB_STATUS_W-1:0] v;
    for (int b = 0; b < SMB_STATUS_W; b++) begin
      v = '0;
      v[b] = 1'b1;
      check_all(v);
    end
  endtask

  // all set: reserved stay zero; then all clear without latching
  task automatic test_all_then_clear;
    logic [7:0] d;
    check_all('1);
    read_reg(8'h70, d);
    check(d, 8'h00);
    read_reg(8'hff, d);
    check(d, 8'h00);
    check_all('0);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    status_i = '0;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    errors = 0;
    samples_checked = 0;
    tick(4);
    rst_n <= 1'b1;
    tick(3);
    test_reset_values();
    test_walk_one();
    test_all_then_clear();
    summarize();
  end

  initial begin
    tick(60000);
    errors++;
    summarize();
  end

endmodule // smb_status_bank_test
